//--- rtl/vps_voltage_stages.sv
// Zero-sequence overvoltage and undervoltage stage decision logic.
// Assumes measurement and control flags on the system clock;
// block inputs are substation pins.
////////////////////////////////////////////////////////////////////////////////
module vps_voltage_stages #(
  parameter int TICK_CYCLES = vps_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Filtered measurement phasors
  input wire logic [2:0][vps_pkg::VIN_W-1:0] v_re_i,
  input wire logic [2:0][vps_pkg::VIN_W-1:0] v_im_i,
  input wire logic [vps_pkg::VIN_W-1:0] fourth_voltage_input_re_i,
  input wire logic [vps_pkg::VIN_W-1:0] fourth_voltage_input_im_i,
  input wire logic [2:0][vps_pkg::VIN_W-1:0] cur_mag_i,
  input wire logic [vps_pkg::VIN_W-1:0] pole_open_current_level_i,
  // Central function control state
  input wire logic [2:0] fuse_fail_i,
  input wire logic spole_dead_i,
  input wire logic [2:0] pole_open_i,
  // Substation binary inputs
  input wire logic pe_under_block_in_i,
  input wire logic pp_under_block_in_i,
  input wire logic posseq_under_block_in_i,
  input wire logic zeroseq_over_block_in_i,
  input wire logic vt_breaker_tripped_in_i,
  // Settings
  input wire logic [1:0] pe_mode_i,
  input wire logic [1:0] pp_mode_i,
  input wire logic [1:0] posseq_mode_i,
  input wire logic [1:0] zeroseq_mode_i,
  input wire logic [1:0] fourth_mode_i,
  input wire logic [vps_pkg::FACTOR_W-1:0] delta_factor_i,
  input wire logic pe_under_current_gate_en_i,
  input wire logic pp_under_current_gate_en_i,
  input wire logic posseq_under_current_gate_en_i,
  input wire logic [vps_pkg::VIN_W-1:0] pe_under_stage1_level_i,
  input wire logic [vps_pkg::VIN_W-1:0] pe_under_stage2_level_i,
  input wire logic [vps_pkg::VIN_W-1:0] pp_under_stage1_level_i,
  input wire logic [vps_pkg::VIN_W-1:0] pp_under_stage2_level_i,
  input wire logic [vps_pkg::VIN_W-1:0] posseq_under_stage1_level_i,
  input wire logic [vps_pkg::VIN_W-1:0] posseq_under_stage2_level_i,
  input wire logic [vps_pkg::VIN_W-1:0] zeroseq_over_stage1_level_i,
  input wire logic [vps_pkg::VIN_W-1:0] zeroseq_over_stage2_level_i,
  input wire logic [vps_pkg::RATIO_W-1:0] pe_under_ratio_i,
  input wire logic [vps_pkg::RATIO_W-1:0] pp_under_ratio_i,
  input wire logic [vps_pkg::RATIO_W-1:0] posseq_under_ratio_i,
  input wire logic [vps_pkg::RATIO_W-1:0] zeroseq_over_ratio_i,
  input wire logic [vps_pkg::DELAY_W-1:0] pe_under_stage1_delay_i,
  input wire logic [vps_pkg::DELAY_W-1:0] pe_under_stage2_delay_i,
  input wire logic [vps_pkg::DELAY_W-1:0] pp_under_stage1_delay_i,
  input wire logic [vps_pkg::DELAY_W-1:0] pp_under_stage2_delay_i,
  input wire logic [vps_pkg::DELAY_W-1:0] posseq_under_stage1_delay_i,
  input wire logic [vps_pkg::DELAY_W-1:0] posseq_under_stage2_delay_i,
  input wire logic [vps_pkg::DELAY_W-1:0] zeroseq_over_stage1_delay_i,
  input wire logic [vps_pkg::DELAY_W-1:0] zeroseq_over_stage2_delay_i,
  // Indications
  output logic [5:0] pe_phase_pickup_o,
  output logic [1:0] pe_pickup_o,
  output logic [5:0] pp_phase_pickup_o,
  output logic [1:0] pp_pickup_o,
  output logic [1:0] posseq_pickup_o,
  output logic [1:0] zeroseq_pickup_o,
  output logic [7:0] stage_timeout_o,
  output logic pe_trip_o,
  output logic pp_trip_o,
  output logic posseq_trip_o,
  output logic zeroseq_trip_o
);
  localparam int CW = vps_pkg::COMP_W;
  localparam int MW = vps_pkg::MAG_W;
  localparam int LW = vps_pkg::LVL_W;

  function automatic logic signed [CW-1:0] ext(input logic [15:0] x);
    ext = {{(CW-16){x[15]}}, x};
  endfunction : ext

  function automatic logic [MW-1:0] mag_sq(input logic signed [CW-1:0] re,
                                           input logic signed [CW-1:0] im);
    logic signed [2*CW-1:0] pr;
    logic signed [2*CW-1:0] pi;
    pr = re * re;
    pi = im * im;
    mag_sq = {2'b00, pr} + {2'b00, pi};
  endfunction : mag_sq

  function automatic logic signed [CW-1:0] rot(input logic signed [CW-1:0] x);
    logic signed [CW+16:0] p;
    p = x * $signed({1'b0, vps_pkg::ROT_K});
    rot = p[CW+vps_pkg::ROT_FRAC-1:vps_pkg::ROT_FRAC];
  endfunction : rot

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [vps_pkg::NUM_PIN-1:0] pin_meta;
  logic [vps_pkg::NUM_PIN-1:0] pin_sync;
  logic [vps_pkg::NUM_PIN-1:0] pin_raw;
  logic pe_blk_in;
  logic pp_blk_in;
  logic ps_blk_in;
  logic zs_blk_in;
  logic vt_trip;

  assign pin_raw = {vt_breaker_tripped_in_i, zeroseq_over_block_in_i,
                    posseq_under_block_in_i, pp_under_block_in_i,
                    pe_under_block_in_i};

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign pe_blk_in = pin_sync[0];
  assign pp_blk_in = pin_sync[1];
  assign ps_blk_in = pin_sync[2];
  assign zs_blk_in = pin_sync[3];
  assign vt_trip = pin_sync[4];

  ////////////////////////////////////////////////////////////////////////////
  // Processing tick divider
  logic [31:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived voltage quantities
  logic signed [CW-1:0] ph_re [0:2];
  logic signed [CW-1:0] ph_im [0:2];
  logic signed [CW-1:0] lp_re [0:2];
  logic signed [CW-1:0] lp_im [0:2];
  logic signed [CW-1:0] ps_re;
  logic signed [CW-1:0] ps_im;
  logic signed [CW-1:0] sum_re;
  logic signed [CW-1:0] sum_im;
  logic signed [CW+16:0] dl_re_p;
  logic signed [CW+16:0] dl_im_p;
  logic signed [CW-1:0] zs_re;
  logic signed [CW-1:0] zs_im;
  logic [MW-1:0] ph_mag [0:2];
  logic [MW-1:0] lp_mag [0:2];
  logic [MW-1:0] ps_mag;
  logic [MW-1:0] zs_mag;
  logic [2:0] flow;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_phase
      assign ph_re[g] = ext(v_re_i[g]);
      assign ph_im[g] = ext(v_im_i[g]);
      assign lp_re[g] = ext(v_re_i[g]) - ext(v_re_i[(g + 1) % 3]);
      assign lp_im[g] = ext(v_im_i[g]) - ext(v_im_i[(g + 1) % 3]);
      assign flow[g] = cur_mag_i[g] > pole_open_current_level_i;
    end
  endgenerate

  // Scaled by three: no divider; levels tripled instead
  assign ps_re = ph_re[0] - ((ph_re[1] + ph_re[2]) >>> 1)
               + rot(ph_im[2] - ph_im[1]);
  assign ps_im = ph_im[0] - ((ph_im[1] + ph_im[2]) >>> 1)
               + rot(ph_re[1] - ph_re[2]);

  assign sum_re = ph_re[0] + ph_re[1] + ph_re[2];
  assign sum_im = ph_im[0] + ph_im[1] + ph_im[2];
  assign dl_re_p = ext(fourth_voltage_input_re_i)
                 * $signed({1'b0, delta_factor_i});
  assign dl_im_p = ext(fourth_voltage_input_im_i)
                 * $signed({1'b0, delta_factor_i});
  assign zs_re = (fourth_mode_i == vps_pkg::FOURTH_DELTA)
               ? dl_re_p[CW+vps_pkg::FACTOR_FRAC-1:vps_pkg::FACTOR_FRAC]
               : (fourth_mode_i == vps_pkg::FOURTH_SINGLE)
               ? ext(fourth_voltage_input_re_i) : sum_re;
  assign zs_im = (fourth_mode_i == vps_pkg::FOURTH_DELTA)
               ? dl_im_p[CW+vps_pkg::FACTOR_FRAC-1:vps_pkg::FACTOR_FRAC]
               : (fourth_mode_i == vps_pkg::FOURTH_SINGLE)
               ? ext(fourth_voltage_input_im_i) : sum_im;

  // Registered magnitudes break the multiplier path
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ph_mag <= '{default: '0};
      lp_mag <= '{default: '0};
      ps_mag <= '0;
      zs_mag <= '0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        ph_mag[i] <= mag_sq(ph_re[i], ph_im[i]);
        lp_mag[i] <= mag_sq(lp_re[i], lp_im[i]);
      end
      ps_mag <= mag_sq(ps_re, ps_im);
      zs_mag <= mag_sq(zs_re, zs_im);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blocking
  logic int_blk;
  logic pe_on [0:1];
  logic pp_on [0:1];
  logic ps_on [0:1];
  logic zs_on [0:1];
  logic pe_ok [0:1];
  logic ps_ok [0:1];
  logic zs_ok [0:1];
  logic [2:0] lp_fail;
  logic [2:0] lp_open;
  logic [2:0] lp_flow;

  assign int_blk = (|fuse_fail_i) || vt_trip;

  generate
    for (g = 0; g < 2; g++)
    begin : g_stage_blk
      assign pe_on[g] = pe_mode_i != vps_pkg::MODE_OFF;
      assign pp_on[g] = pp_mode_i != vps_pkg::MODE_OFF;
      assign ps_on[g] = posseq_mode_i != vps_pkg::MODE_OFF;
      assign zs_on[g] = zeroseq_mode_i != vps_pkg::MODE_OFF;
      assign pe_ok[g] = pe_on[g] && !pe_blk_in && !int_blk
        && !(spole_dead_i && vps_pkg::can_trip(pe_mode_i, g));
      assign ps_ok[g] = ps_on[g] && !ps_blk_in && !int_blk
        && !spole_dead_i;
      // Single-phase fourth input: no internal blocking
      assign zs_ok[g] = zs_on[g] && !zs_blk_in
        && ((fourth_mode_i == vps_pkg::FOURTH_SINGLE)
            || !(int_blk || spole_dead_i));
    end
    for (g = 0; g < 3; g++)
    begin : g_loop_blk
      assign lp_fail[g] = fuse_fail_i[g] || fuse_fail_i[(g + 1) % 3]
                        || vt_trip;
      assign lp_open[g] = pole_open_i[g] || pole_open_i[(g + 1) % 3];
      assign lp_flow[g] = flow[g] || flow[(g + 1) % 3];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Comparator channels
  logic [MW-1:0] ch_mag [0:vps_pkg::NUM_CH-1];
  logic [LW-1:0] ch_lvl [0:vps_pkg::NUM_CH-1];
  logic [vps_pkg::RATIO_W-1:0] ch_ratio [0:vps_pkg::NUM_CH-1];
  logic [vps_pkg::NUM_CH-1:0] ch_en;
  logic [vps_pkg::NUM_CH-1:0] ch_pick;
  logic [15:0] pe_lvl [0:1];
  logic [15:0] pp_lvl [0:1];
  logic [15:0] ps_lvl [0:1];
  logic [15:0] zs_lvl [0:1];

  assign pe_lvl[0] = pe_under_stage1_level_i;
  assign pe_lvl[1] = pe_under_stage2_level_i;
  assign pp_lvl[0] = pp_under_stage1_level_i;
  assign pp_lvl[1] = pp_under_stage2_level_i;
  assign ps_lvl[0] = posseq_under_stage1_level_i;
  assign ps_lvl[1] = posseq_under_stage2_level_i;
  assign zs_lvl[0] = zeroseq_over_stage1_level_i;
  assign zs_lvl[1] = zeroseq_over_stage2_level_i;

  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_stage
      for (g = 0; g < 3; g++)
      begin : g_ph
        localparam int PE = vps_pkg::CH_PE + s * 3 + g;
        localparam int PP = vps_pkg::CH_PP + s * 3 + g;
        assign ch_mag[PE] = ph_mag[g];
        assign ch_lvl[PE] = {2'b00, pe_lvl[s]};
        assign ch_ratio[PE] = pe_under_ratio_i;
        assign ch_en[PE] = pe_ok[s]
          && (!pe_under_current_gate_en_i || flow[g]);
        assign ch_mag[PP] = lp_mag[g];
        assign ch_lvl[PP] = {2'b00, pp_lvl[s]};
        assign ch_ratio[PP] = pp_under_ratio_i;
        assign ch_en[PP] = pp_on[s] && !pp_blk_in && !lp_fail[g]
          && !(spole_dead_i && lp_open[g]
               && vps_pkg::can_trip(pp_mode_i, s))
          && (!pp_under_current_gate_en_i || lp_flow[g]);
      end
      assign ch_mag[vps_pkg::CH_PS + s] = ps_mag;
      assign ch_lvl[vps_pkg::CH_PS + s] = {2'b00, ps_lvl[s]}
                                         + {1'b0, ps_lvl[s], 1'b0};
      assign ch_ratio[vps_pkg::CH_PS + s] = posseq_under_ratio_i;
      assign ch_en[vps_pkg::CH_PS + s] = ps_ok[s]
        && (!posseq_under_current_gate_en_i || (|flow));
      assign ch_mag[vps_pkg::CH_ZS + s] = zs_mag;
      assign ch_lvl[vps_pkg::CH_ZS + s] = {2'b00, zs_lvl[s]};
      assign ch_ratio[vps_pkg::CH_ZS + s] = zeroseq_over_ratio_i;
      assign ch_en[vps_pkg::CH_ZS + s] = zs_ok[s];
    end
    for (g = 0; g < vps_pkg::NUM_CH; g++)
    begin : g_ch
      vps_level_stage #(
        .UNDER(g < vps_pkg::CH_ZS)
      ) u_level (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .en_i(ch_en[g]),
        .mag_sq_i(ch_mag[g]),
        .level_i(ch_lvl[g]),
        .ratio_i(ch_ratio[g]),
        .pickup_o(ch_pick[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Stage pickups and shared delay timers
  logic [vps_pkg::NUM_STG-1:0] stg_pick;
  logic [vps_pkg::NUM_STG-1:0] stg_expired;
  logic [vps_pkg::NUM_STG-1:0] stg_trip_ok;
  logic [vps_pkg::DELAY_W-1:0] stg_delay [0:vps_pkg::NUM_STG-1];
  logic [5:0] pp_phase;

  assign stg_delay[0] = pe_under_stage1_delay_i;
  assign stg_delay[1] = pe_under_stage2_delay_i;
  assign stg_delay[2] = pp_under_stage1_delay_i;
  assign stg_delay[3] = pp_under_stage2_delay_i;
  assign stg_delay[4] = posseq_under_stage1_delay_i;
  assign stg_delay[5] = posseq_under_stage2_delay_i;
  assign stg_delay[6] = zeroseq_over_stage1_delay_i;
  assign stg_delay[7] = zeroseq_over_stage2_delay_i;

  generate
    for (s = 0; s < 2; s++)
    begin : g_pick
      assign stg_pick[vps_pkg::STG_PE + s] =
        |ch_pick[vps_pkg::CH_PE + s * 3 +: 3];
      assign stg_pick[vps_pkg::STG_PP + s] =
        |ch_pick[vps_pkg::CH_PP + s * 3 +: 3];
      assign stg_pick[vps_pkg::STG_PS + s] = ch_pick[vps_pkg::CH_PS + s];
      assign stg_pick[vps_pkg::STG_ZS + s] = ch_pick[vps_pkg::CH_ZS + s];
      assign stg_trip_ok[vps_pkg::STG_PE + s] = vps_pkg::can_trip(pe_mode_i, s);
      assign stg_trip_ok[vps_pkg::STG_PP + s] = vps_pkg::can_trip(pp_mode_i, s);
      assign stg_trip_ok[vps_pkg::STG_PS + s] =
        vps_pkg::can_trip(posseq_mode_i, s);
      assign stg_trip_ok[vps_pkg::STG_ZS + s] =
        vps_pkg::can_trip(zeroseq_mode_i, s);
      for (g = 0; g < 3; g++)
      begin : g_both
        // A phase shows when either of its loops picks up
        assign pp_phase[s * 3 + g] = ch_pick[vps_pkg::CH_PP + s * 3 + g]
          || ch_pick[vps_pkg::CH_PP + s * 3 + (g + 2) % 3];
      end
    end
    for (g = 0; g < vps_pkg::NUM_STG; g++)
    begin : g_timer
      vps_delay_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .run_i(stg_pick[g]),
        .delay_i(stg_delay[g]),
        .expired_o(stg_expired[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered indications
  logic [vps_pkg::NUM_STG-1:0] stg_trip;

  assign stg_trip = stg_expired & stg_trip_ok & stg_pick;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      pe_phase_pickup_o <= '0;
      pe_pickup_o <= '0;
      pp_phase_pickup_o <= '0;
      pp_pickup_o <= '0;
      posseq_pickup_o <= '0;
      zeroseq_pickup_o <= '0;
      stage_timeout_o <= '0;
      pe_trip_o <= 1'b0;
      pp_trip_o <= 1'b0;
      posseq_trip_o <= 1'b0;
      zeroseq_trip_o <= 1'b0;
    end
    else
    begin
      pe_phase_pickup_o <= ch_pick[vps_pkg::CH_PE +: 6];
      pe_pickup_o <= stg_pick[vps_pkg::STG_PE +: 2];
      pp_phase_pickup_o <= pp_phase;
      pp_pickup_o <= stg_pick[vps_pkg::STG_PP +: 2];
      posseq_pickup_o <= stg_pick[vps_pkg::STG_PS +: 2];
      zeroseq_pickup_o <= stg_pick[vps_pkg::STG_ZS +: 2];
      stage_timeout_o <= stg_expired & stg_pick;
      pe_trip_o <= |stg_trip[vps_pkg::STG_PE +: 2];
      pp_trip_o <= |stg_trip[vps_pkg::STG_PP +: 2];
      posseq_trip_o <= |stg_trip[vps_pkg::STG_PS +: 2];
      zeroseq_trip_o <= |stg_trip[vps_pkg::STG_ZS +: 2];
    end
  end
endmodule : vps_voltage_stages

//--- rtl/vps_pkg.sv
// Constants shared by the voltage protection stage logic.
// Assumes one 250 MHz clock and filtered phasors from measurement logic.
//
// Contract
// - Zero-seq stages blocked in single-pole dead time.
// - No fourth-input voltage: 3U0 is the phase sum.
// - Open-delta fourth input: 3U0 is input times factor.
// - Single-phase fourth input: only its block pin acts.
// - Two phase-earth levels per phase; pickups per phase.
// - General pickup per stage; dropout ratio sets hysteresis.
// - Stage pickup runs one shared timer; expiry: timeout, trip.
// - Phase-earth gate needs that phase's current flow.
// - Phase-earth blocked by pin, fuse failure or VT trip.
// - Dead time blocks undervoltage stages able to trip.
// - Phase-phase pickup shows both loop phases.
// - Phase-phase gate met by flow in either loop phase.
// - Fuse failure or VT trip blocks affected loops only.
// - Dead time blocks open-phase loops of tripping stages.
// - Positive sequence is (U1 + a U2 + a^2 U3)/3, a at 120 deg.
// - Pos-seq feeds two stages, own delay each.
// - Pos-seq gate needs flow in any phase.
// - Pos-seq blocked by pin, fuse failure or VT trip.
// - Pos-seq blocked throughout dead time.
////////////////////////////////////////////////////////////////////////////////
package vps_pkg;
  localparam int VIN_W = 16;
  localparam int COMP_W = 24;
  localparam int MAG_W = 50;
  localparam int LVL_W = 18;
  localparam int RATIO_W = 8;
  localparam int RATIO_FRAC = 7;
  localparam int REL_W = LVL_W + RATIO_W - RATIO_FRAC;
  localparam int FACTOR_W = 16;
  localparam int FACTOR_FRAC = 8;
  localparam int ROT_FRAC = 15;
  localparam int DELAY_W = 16;
  localparam int NUM_STG = 8;
  localparam int NUM_CH = 16;
  localparam int NUM_PIN = 5;
  // Sqrt(3)/2 in Q1.15 for the 120 degree rotation
  localparam logic [15:0] ROT_K = 16'h6EDA;
  // Typical phase-to-delta factor 1.73 in Q8.8
  localparam logic [15:0] DELTA_FACTOR_TYP = 16'h01BB;
  // Processing tick of 1 ms
  localparam int TICK_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  // Stage operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_ALARM = 2'h2;
  localparam logic [1:0] MODE_ALARM1_TRIP2 = 2'h3;
  // Use of the fourth voltage input
  localparam logic [1:0] FOURTH_NONE = 2'h0;
  localparam logic [1:0] FOURTH_DELTA = 2'h1;
  localparam logic [1:0] FOURTH_SINGLE = 2'h2;
  // Stage indices of the timer vector
  localparam int STG_PE = 0;
  localparam int STG_PP = 2;
  localparam int STG_PS = 4;
  localparam int STG_ZS = 6;
  // Channel bases of the comparator vector
  localparam int CH_PE = 0;
  localparam int CH_PP = 6;
  localparam int CH_PS = 12;
  localparam int CH_ZS = 14;

  function automatic logic can_trip(input logic [1:0] mode, input int stage);
    can_trip = (mode == MODE_ON)
             || ((mode == MODE_ALARM1_TRIP2) && (stage == 1));
  endfunction : can_trip
endpackage : vps_pkg

//--- rtl/vps_level_stage.sv
// One threshold comparator with dropout hysteresis on squared magnitudes.
// Assumes inputs from logic on the same clock.
////////////////////////////////////////////////////////////////////////////////
module vps_level_stage #(
  parameter bit UNDER = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [vps_pkg::MAG_W-1:0] mag_sq_i,
  input wire logic [vps_pkg::LVL_W-1:0] level_i,
  input wire logic [vps_pkg::RATIO_W-1:0] ratio_i,
  output logic pickup_o
);
  logic [vps_pkg::LVL_W+vps_pkg::RATIO_W-1:0] scaled;
  logic [vps_pkg::REL_W-1:0] rel_lvl;
  logic [2*vps_pkg::LVL_W-1:0] thr_prod;
  logic [2*vps_pkg::REL_W-1:0] rel_prod;
  logic [vps_pkg::MAG_W-1:0] thr_sq;
  logic [vps_pkg::MAG_W-1:0] rel_sq;
  logic start_hit;
  logic hold_hit;
  logic next_pickup;

  assign scaled = level_i * ratio_i;
  assign rel_lvl = scaled[$left(scaled):vps_pkg::RATIO_FRAC];
  assign thr_prod = level_i * level_i;
  assign rel_prod = rel_lvl * rel_lvl;
  assign thr_sq = {{(vps_pkg::MAG_W-2*vps_pkg::LVL_W){1'b0}}, thr_prod};
  assign rel_sq = {{(vps_pkg::MAG_W-2*vps_pkg::REL_W){1'b0}}, rel_prod};
  // Squares avoid a root; ordering of magnitudes is kept
  assign start_hit = UNDER ? (mag_sq_i < thr_sq) : (mag_sq_i > thr_sq);
  assign hold_hit = UNDER ? (mag_sq_i <= rel_sq) : (mag_sq_i >= rel_sq);
  assign next_pickup = en_i && (pickup_o ? hold_hit : start_hit);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pickup_o <= 1'b0;
    else
      pickup_o <= next_pickup;
  end
endmodule : vps_level_stage

//--- rtl/vps_delay_timer.sv
// Stage delay timer: counts ticks while pickup persists.
// Assumes a one-cycle tick pulse from the divider of the top module.
////////////////////////////////////////////////////////////////////////////////
module vps_delay_timer (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [vps_pkg::DELAY_W-1:0] delay_i,
  output logic expired_o
);
  logic [vps_pkg::DELAY_W-1:0] count;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !run_i)
    begin
      count <= '0;
      expired_o <= 1'b0;
    end
    else
    begin
      if (tick_i && !expired_o)
        count <= count + 1'b1;
      expired_o <= (count >= delay_i);
    end
  end
endmodule : vps_delay_timer

//--- verification/vps_chk.sv
// Assertions on stage outputs against top-port causes.
// Assumes a bind into the top; pins add two sync cycles.
////////////////////////////////////////////////////////////////////////////////
module vps_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] fuse_fail_i,
  input wire logic spole_dead_i,
  input wire logic vt_breaker_tripped_in_i,
  input wire logic [1:0] pe_mode_i,
  input wire logic [1:0] fourth_mode_i,
  input wire logic [5:0] pe_phase_pickup_o,
  input wire logic [1:0] pe_pickup_o,
  input wire logic [5:0] pp_phase_pickup_o,
  input wire logic [1:0] posseq_pickup_o,
  input wire logic [1:0] zeroseq_pickup_o,
  input wire logic [7:0] stage_timeout_o,
  input wire logic pe_trip_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  zs_dead_blk_a: assert property (
    (spole_dead_i && fourth_mode_i != vps_pkg::FOURTH_SINGLE)[*5]
    |-> zeroseq_pickup_o == 2'h0) else $error("ZS in dead time");
  ps_dead_blk_a: assert property (spole_dead_i[*5]
    |-> posseq_pickup_o == 2'h0) else $error("PS in dead time");
  pe_fuse_blk_a: assert property ((fuse_fail_i == 3'h7)[*5]
    |-> pe_pickup_o == 2'h0) else $error("PE with fuse fail");
  ps_vt_blk_a: assert property (vt_breaker_tripped_in_i[*7]
    |-> posseq_pickup_o == 2'h0) else $error("PS with VT trip");
  pe_general_a: assert property (pe_pickup_o ==
    {|pe_phase_pickup_o[5:3], |pe_phase_pickup_o[2:0]}) else $error("General");
  pp_pair_a: assert property ($countones(pp_phase_pickup_o[2:0]) != 1)
    else $error("Loop single phase");
  pe_timer_a: assert property ($rose(stage_timeout_o[0])
    |-> $past(pe_pickup_o[0], 2)) else $error("Timeout early");
  pe_alarm_a: assert property ((pe_mode_i == vps_pkg::MODE_ALARM)[*3]
    |-> !pe_trip_o) else $error("Trip in alarm mode");
  pe_drop_clr_a: assert property ($fell(pe_pickup_o[0])
    |-> ##[0:2] !stage_timeout_o[0]) else $error("Timer kept");
endmodule : vps_chk
bind vps_voltage_stages vps_chk i_vps_chk (.*);

//--- verification/vps_sub_model.sv
// Substation side: block pins and external reclose gear.
// Assumes bench commands; pins change on the falling edge.
////////////////////////////////////////////////////////////////////////////////
module vps_sub_model (
  input wire logic clk_sys_i,
  input wire logic spole_trip_i,
  input wire logic [3:0] blk_cmd_i,
  output logic [4:0] pins_o = 5'h00
);
  // Zero-seq block spans the trip
  always @(negedge clk_sys_i)
    pins_o <= {spole_trip_i, blk_cmd_i};
endmodule : vps_sub_model

//--- verification/tb_top.sv
// Bench: phasor steps and block pins against stage decisions.
// Assumes a 10-cycle tick so one-tick delays pass fast.
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] D = 16'h0001;
  localparam logic [7:0] RU = 8'h86;
  int err_total = 0, checks_done = 0;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, spole_dead_i = 1'b0, spole_trip = 1'b0;
  logic pe_under_current_gate_en_i = 1'b0, pp_under_current_gate_en_i = 1'b0;
  logic posseq_under_current_gate_en_i = 1'b0, pe_trip_o, pp_trip_o;
  logic posseq_trip_o, zeroseq_trip_o;
  logic [3:0] blk_cmd = 4'h0;
  logic [2:0] fuse_fail_i = 3'h0, pole_open_i = 3'h0;
  logic [1:0] fourth_mode_i = 2'h0, pe_mode_i = 2'h1, pp_mode_i = 2'h1;
  logic [1:0] posseq_mode_i = 2'h1, zeroseq_mode_i = 2'h1, pe_pickup_o;
  logic [1:0] pp_pickup_o, posseq_pickup_o, zeroseq_pickup_o;
  logic [5:0] pe_phase_pickup_o, pp_phase_pickup_o;
  logic [7:0] stage_timeout_o, zeroseq_over_ratio_i = 8'h7D;
  logic [7:0] pe_under_ratio_i = RU, pp_under_ratio_i = RU;
  logic [7:0] posseq_under_ratio_i = RU;
  logic [2:0][15:0] v_re_i, v_im_i, cur_mag_i = {3{16'h0200}};
  logic [15:0] fourth_voltage_input_re_i = 16'h0, delta_factor_i = 16'h01BB;
  logic [15:0] fourth_voltage_input_im_i = 16'h0;
  logic [15:0] pole_open_current_level_i = 16'h0100;
  // Levels apart so stages differ
  logic [15:0] pe_under_stage1_level_i = 16'h2000;
  logic [15:0] pe_under_stage2_level_i = 16'h1000;
  logic [15:0] pp_under_stage1_level_i = 16'h5000;
  logic [15:0] pp_under_stage2_level_i = 16'h4800;
  logic [15:0] posseq_under_stage1_level_i = 16'h2000;
  logic [15:0] posseq_under_stage2_level_i = 16'h1000;
  logic [15:0] zeroseq_over_stage1_level_i = 16'h1000;
  logic [15:0] zeroseq_over_stage2_level_i = 16'h1800;
  logic [15:0] pe_under_stage1_delay_i = D, pe_under_stage2_delay_i = D;
  logic [15:0] pp_under_stage1_delay_i = D, pp_under_stage2_delay_i = D;
  logic [15:0] posseq_under_stage1_delay_i = D, posseq_under_stage2_delay_i = D;
  logic [15:0] zeroseq_over_stage1_delay_i = D, zeroseq_over_stage2_delay_i = D;
  wire logic pe_under_block_in_i, pp_under_block_in_i, posseq_under_block_in_i;
  wire logic zeroseq_over_block_in_i, vt_breaker_tripped_in_i;
  vps_voltage_stages #(.TICK_CYCLES(10)) i_vps_voltage_stages (.*);
  vps_sub_model i_vps_sub_model (.clk_sys_i, .spole_trip_i(spole_trip),
    .blk_cmd_i(blk_cmd), .pins_o({zeroseq_over_block_in_i,
    vt_breaker_tripped_in_i, posseq_under_block_in_i, pp_under_block_in_i,
    pe_under_block_in_i}));
  always #2 clk_sys_i = ~clk_sys_i;
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic chk(string n, logic [7:0] e, s);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bal();
    v_re_i = {16'hE000, 16'hE000, 16'h4000};
    v_im_i = {16'h376D, 16'hC893, 16'h0000};
  endtask : bal
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    bal();
    cyc(12);
    rst_i = 1'b0;
    cyc(8);
    v_re_i[0] = 16'h0800;
    cyc(8);
    chk("pe phases", 8'h09, pe_phase_pickup_o);
    chk("zs pickup", 8'h03, zeroseq_pickup_o);
    chk("pp phases", 8'h3F, pp_phase_pickup_o);
    cyc(40);
    chk("timeouts", 8'hCF, stage_timeout_o);
    chk("trips", 8'h0D,
      {pe_trip_o, pp_trip_o, posseq_trip_o, zeroseq_trip_o});
    pe_under_current_gate_en_i = 1'b1;
    cur_mag_i[0] = 16'h0000;
    cyc(8);
    chk("pe gated", 8'h00, pe_phase_pickup_o[2:0]);
    $display("PE test done");
    {spole_dead_i, pole_open_i, pe_mode_i} = {1'b1, 3'h1, 2'h2};
    pe_under_current_gate_en_i = 1'b0;
    cyc(8);
    chk("zs dead", 8'h00, zeroseq_pickup_o);
    chk("pe alarm", 8'h03, pe_pickup_o);
    chk("pe no trip", 8'h00, pe_trip_o);
    {fourth_mode_i, fourth_voltage_input_re_i} = {2'h2, 16'h2000};
    cyc(8);
    chk("u4 single", 8'h03, zeroseq_pickup_o);
    spole_trip = 1'b1;
    cyc(8);
    chk("u4 blocked", 8'h00, zeroseq_pickup_o);
    {spole_trip, spole_dead_i, pe_mode_i, fuse_fail_i} = {4'h3, 3'h7};
    cyc(8);
    chk("pe fuse", 8'h00, pe_pickup_o);
    {fuse_fail_i, blk_cmd} = {3'h0, 4'h8};
    cyc(8);
    chk("pe vt", 8'h00, pe_pickup_o);
    $display("Blocking test done");
    {blk_cmd, fourth_mode_i, fourth_voltage_input_re_i} = {6'h1, 16'h0800};
    bal();
    cyc(8);
    chk("pe release", 8'h00, {pe_pickup_o, stage_timeout_o[1:0]});
    chk("delta low", 8'h00, zeroseq_pickup_o);
    fourth_voltage_input_re_i = 16'h0A00;
    cyc(8);
    chk("delta high", 8'h01, zeroseq_pickup_o);
    $display("ZS test done");
    {v_re_i, v_im_i, fourth_mode_i} = '0;
    cyc(8);
    chk("u1 pickup", 8'h03, posseq_pickup_o);
    spole_dead_i = 1'b1;
    cyc(8);
    chk("u1 dead", 8'h00, posseq_pickup_o);
    {spole_dead_i, posseq_under_current_gate_en_i, cur_mag_i} = {2'h1, 48'h0};
    cyc(8);
    chk("u1 gated", 8'h00, posseq_pickup_o);
    $display("PS test done");
    finish_test();
  end
  // Tests need about 160 cycles
  initial
  begin
    #20000;
    err_total++;
    finish_test();
  end
endmodule : tb_top
